/* File: hw/uart_regmap_pkg.sv */
// Purpose: Shared constants and types for the channel register map decode.
// Assumes: One channel of a dual UART, 8-bit host bus, 3-bit register address.
// Notes:   Configuration registers reset to zero; register contents are held in the decode bank, not here.
package uart_regmap_pkg;

    // Register addresses; several registers share one address.
    localparam logic [2:0] ADDR_HOLD_DIVL  = 3'h0;
    localparam logic [2:0] ADDR_INTEN_DIVH = 3'h1;
    localparam logic [2:0] ADDR_FIFO_FEAT  = 3'h2;
    localparam logic [2:0] ADDR_LINE       = 3'h3;
    localparam logic [2:0] ADDR_MODEM_RES1 = 3'h4;
    localparam logic [2:0] ADDR_LSTAT_RES2 = 3'h5;
    localparam logic [2:0] ADDR_MSTAT_PAU1 = 3'h6;
    localparam logic [2:0] ADDR_SCR_PAU2   = 3'h7;

    // Gating values and bit positions.
    localparam logic [7:0] LINE_ENH_KEY   = 8'hbf;
    localparam int         LINE_DIV_BIT   = 7;
    localparam int         FEAT_ENH_BIT   = 4;
    localparam int         MODEM_LVL_BIT  = 6;
    localparam int         MODEM_LOOP_BIT = 4;
    localparam int         MODEM_RDY_BIT  = 2;

    // Bits that only change while enhanced functions are enabled.
    localparam logic [7:0] INTEN_ENH_MASK = 8'hf0;
    localparam logic [7:0] FIFO_ENH_MASK  = 8'h30;
    localparam logic [7:0] MODEM_ENH_MASK = 8'he0;
    // FIFO clear bits return to zero on their own.
    localparam logic [7:0] FIFO_SELF_CLR  = 8'h06;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [1:0] FRDY_ZERO      = 2'h0;

    // Strobe indices for the edge detector.
    localparam int         STB_RD         = 0;
    localparam int         STB_WR         = 1;
    localparam int         STB_COUNT      = 2;

    // Register selected by an access; one-hot.
    typedef enum logic [20:0] {
        SEL_NONE       = 21'h000001,
        SEL_RX_HOLD    = 21'h000002,
        SEL_TX_HOLD    = 21'h000004,
        SEL_DIV_LOW    = 21'h000008,
        SEL_DIV_HIGH   = 21'h000010,
        SEL_INT_EN     = 21'h000020,
        SEL_FIFO_CTRL  = 21'h000040,
        SEL_INT_IDENT  = 21'h000080,
        SEL_ENH_FEAT   = 21'h000100,
        SEL_FLOW_THR   = 21'h000200,
        SEL_LINE_CTRL  = 21'h000400,
        SEL_MODEM_CTRL = 21'h000800,
        SEL_LINE_STAT  = 21'h001000,
        SEL_MODEM_STAT = 21'h002000,
        SEL_SCRATCH    = 21'h004000,
        SEL_RESUME_1   = 21'h008000,
        SEL_RESUME_2   = 21'h010000,
        SEL_PAUSE_1    = 21'h020000,
        SEL_PAUSE_2    = 21'h040000,
        SEL_TRIG_LVL   = 21'h080000,
        SEL_FIFO_RDY   = 21'h100000
    } reg_sel_e;

    // Software-visible configuration registers.
    typedef struct packed {
        logic [7:0] interrupt_enable;
        logic [7:0] fifo_control;
        logic [7:0] line_control;
        logic [7:0] modem_control;
        logic [7:0] scratch_pad;
        logic [7:0] divisor_low;
        logic [7:0] divisor_high;
        logic [7:0] enhanced_feature;
        logic [7:0] resume_char_1;
        logic [7:0] resume_char_2;
        logic [7:0] pause_char_1;
        logic [7:0] pause_char_2;
        logic [7:0] flow_threshold;
        logic [7:0] trigger_level;
    } cfg_s;

    // Host bus pins of the device, all active-low strobes and selects.
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       rd_n;
        logic       wr_n;
        logic       channel_a_select_n;
        logic       channel_b_select_n;
    } host_bus_s;

    // Read-only state supplied by the datapath around this block.
    typedef struct packed {
        logic [7:0] rx_holding;
        logic [7:0] interrupt_ident;
        logic [7:0] line_status;
        logic [7:0] modem_status;
        logic       rx_fifo_b;
        logic       rx_fifo_a;
        logic       tx_fifo_b;
        logic       tx_fifo_a;
    } status_s;

endpackage : uart_regmap_pkg

/* File: hw/strobe_edge.sv */
// Purpose: Finds the first sampled cycle of each active host strobe.
// Assumes: Strobe levels are synchronous to the clock.
// Notes:   One access per strobe assertion, however long it is held.
`timescale 1ns/1ps
`default_nettype none
module strobe_edge (
    input  wire logic                                  sys_clk_i,
    input  wire logic                                  nrst_i,
    input  wire logic [uart_regmap_pkg::STB_COUNT-1:0] level_i,
    output logic      [uart_regmap_pkg::STB_COUNT-1:0] rise_o
);

    typedef struct packed {
        logic [uart_regmap_pkg::STB_COUNT-1:0] prev;
    } edge_state_s;

    edge_state_s q;
    edge_state_s d;

    // Remember the last level so a held strobe acts only once.
    always_comb
    begin
        d      = q;
        d.prev = level_i;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            q <= '0;
        else
            q <= d;
    end

    // A rise is a level that was low on the previous edge.
    genvar g;
    generate
        for (g = 0; g < uart_regmap_pkg::STB_COUNT; g++)
        begin : g_rise
            assign rise_o[g] = level_i[g] & ~q.prev[g];
        end
    endgenerate

endmodule : strobe_edge
`default_nettype wire

/* File: hw/reg_select.sv */
// Purpose: Maps the address and gating bits to the register an access reaches.
// Assumes: Configuration values are the registered ones, stable during access.
// Notes:   Purely combinational; reads and writes decode separately.
`timescale 1ns/1ps
`default_nettype none
module reg_select (
    input  wire logic [2:0]                  addr_i,
    input  wire uart_regmap_pkg::cfg_s       cfg_i,
    input  wire logic                        both_selected_i,
    output uart_regmap_pkg::reg_sel_e        rd_sel_o,
    output uart_regmap_pkg::reg_sel_e        wr_sel_o
);

    // Shared decode; the write flag picks between the two register sets.
    function automatic uart_regmap_pkg::reg_sel_e pick(
        input logic [2:0]            a,
        input logic                  wr,
        input uart_regmap_pkg::cfg_s c,
        input logic                  both
    );
        logic div;
        logic key;
        logic lvl;
        logic rdy;
        uart_regmap_pkg::reg_sel_e s;
        div = c.line_control[uart_regmap_pkg::LINE_DIV_BIT];
        key = (c.line_control == uart_regmap_pkg::LINE_ENH_KEY);
        lvl = c.enhanced_feature[uart_regmap_pkg::FEAT_ENH_BIT]
            & c.modem_control[uart_regmap_pkg::MODEM_LVL_BIT];
        rdy = both & c.modem_control[uart_regmap_pkg::MODEM_RDY_BIT]
            & ~c.modem_control[uart_regmap_pkg::MODEM_LOOP_BIT];
        s = uart_regmap_pkg::SEL_NONE;
        if (a == uart_regmap_pkg::ADDR_HOLD_DIVL)
            s = div ? uart_regmap_pkg::SEL_DIV_LOW
              : (wr ? uart_regmap_pkg::SEL_TX_HOLD : uart_regmap_pkg::SEL_RX_HOLD);
        else if (a == uart_regmap_pkg::ADDR_INTEN_DIVH)
            s = div ? uart_regmap_pkg::SEL_DIV_HIGH : uart_regmap_pkg::SEL_INT_EN;
        else if (a == uart_regmap_pkg::ADDR_FIFO_FEAT)
            s = key ? uart_regmap_pkg::SEL_ENH_FEAT
              : lvl ? uart_regmap_pkg::SEL_FLOW_THR
              : (wr ? uart_regmap_pkg::SEL_FIFO_CTRL : uart_regmap_pkg::SEL_INT_IDENT);
        else if (a == uart_regmap_pkg::ADDR_LINE)
            s = uart_regmap_pkg::SEL_LINE_CTRL;
        else if (a == uart_regmap_pkg::ADDR_MODEM_RES1)
            s = key ? uart_regmap_pkg::SEL_RESUME_1 : uart_regmap_pkg::SEL_MODEM_CTRL;
        else if (a == uart_regmap_pkg::ADDR_LSTAT_RES2)
            s = key ? uart_regmap_pkg::SEL_RESUME_2 : uart_regmap_pkg::SEL_LINE_STAT;
        else if (a == uart_regmap_pkg::ADDR_MSTAT_PAU1)
            s = key ? uart_regmap_pkg::SEL_PAUSE_1 : uart_regmap_pkg::SEL_MODEM_STAT;
        else
            s = key ? uart_regmap_pkg::SEL_PAUSE_2
              : lvl ? uart_regmap_pkg::SEL_TRIG_LVL
              : (rdy && !wr) ? uart_regmap_pkg::SEL_FIFO_RDY
              : uart_regmap_pkg::SEL_SCRATCH;
        return s;
    endfunction : pick

    // Reads and writes at one address may reach different registers.
    assign rd_sel_o = pick(addr_i, 1'b0, cfg_i, both_selected_i);
    assign wr_sel_o = pick(addr_i, 1'b1, cfg_i, both_selected_i);

endmodule : reg_select
`default_nettype wire

/* File: hw/uart_register_map_decode.sv */
// Purpose: Register bank and access gating for one channel of a dual UART.
// Assumes: Host bus pins are synchronous to sys_clk_i; this block is channel A.
// Notes:   Datapath state (holding, status) arrives on status_i and is only read.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Divisor bytes sit at addresses 0 and 1 only while line control bit 7 is set.
// - Enhanced feature and flow characters appear only when line control equals 0xbf.
// - Flow threshold and trigger level need enhanced enable and modem control bit 6.
// - FIFO-ready summary reads at 7 with both selects low, bit 2 set, no loopback.
// - Prescaler select bit 7 of modem control changes only with enhanced enable.
// - Eight addresses reach 20 8-bit registers; FIFO control write-only, status registers read-only.
// - Address plus gating bits pick the register; reads and writes may differ.
// - Enhanced-only bits, transmit trigger field included, change only with enable set.
module uart_register_map_decode (
    input  wire logic                       sys_clk_i,
    input  wire logic                       nrst_i,
    input  wire uart_regmap_pkg::host_bus_s bus_i,
    input  wire uart_regmap_pkg::status_s   status_i,
    output logic [7:0]                      rdata_o,
    output logic                            data_oe_n_o,
    output logic                            tx_write_o,
    output logic [7:0]                      tx_data_o,
    output logic                            rx_read_o,
    output logic                            fifo_control_write_o,
    output uart_regmap_pkg::cfg_s           config_o
);

    // Whole state of the bank.
    typedef struct packed {
        uart_regmap_pkg::cfg_s cfg;
        logic [7:0]            rdata;
        logic                  data_oe_n;
        logic                  tx_we;
        logic [7:0]            tx_data;
        logic                  rx_re;
        logic                  fifo_we;
    } bank_state_s;

    bank_state_s q;
    bank_state_s d;

    logic [uart_regmap_pkg::STB_COUNT-1:0] level;
    logic [uart_regmap_pkg::STB_COUNT-1:0] rise;
    logic                                  both_selected;
    logic                                  enh_en;
    uart_regmap_pkg::reg_sel_e             rd_sel;
    uart_regmap_pkg::reg_sel_e             wr_sel;
    logic [7:0]                            frdy;

    // Merge a write so that protected bits keep their old value unless enabled.
    function automatic logic [7:0] guarded(
        input logic [7:0] old_v,
        input logic [7:0] new_v,
        input logic [7:0] mask,
        input logic       en
    );
        guarded = en ? new_v : ((old_v & mask) | (new_v & ~mask));
    endfunction : guarded

    // Strobes count only while this channel is selected.
    assign level[uart_regmap_pkg::STB_RD] = ~bus_i.channel_a_select_n & ~bus_i.rd_n;
    assign level[uart_regmap_pkg::STB_WR] = ~bus_i.channel_a_select_n & ~bus_i.wr_n;
    assign both_selected = ~bus_i.channel_a_select_n & ~bus_i.channel_b_select_n;
    assign enh_en = q.cfg.enhanced_feature[uart_regmap_pkg::FEAT_ENH_BIT];

    // Summary of all four FIFO ready flags, padding bits read as zero.
    assign frdy = {uart_regmap_pkg::FRDY_ZERO, status_i.rx_fifo_b, status_i.rx_fifo_a,
                   uart_regmap_pkg::FRDY_ZERO, status_i.tx_fifo_b, status_i.tx_fifo_a};

    strobe_edge u_edge (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .level_i   (level),
        .rise_o    (rise)
    );

    reg_select u_sel (
        .addr_i          (bus_i.addr),
        .cfg_i           (q.cfg),
        .both_selected_i (both_selected),
        .rd_sel_o        (rd_sel),
        .wr_sel_o        (wr_sel)
    );

    // Next-state logic for the bank. Pulses last one cycle; clear bits self-reset.
    always_comb
    begin
        d                  = q;
        d.tx_we            = 1'b0;
        d.rx_re            = 1'b0;
        d.fifo_we          = 1'b0;
        d.cfg.fifo_control = q.cfg.fifo_control & ~uart_regmap_pkg::FIFO_SELF_CLR;
        // Drive the bus for the cycles the read strobe is held, one cycle later.
        d.data_oe_n        = ~level[uart_regmap_pkg::STB_RD];

        // Write path. Registers not named here take no write at all.
        if (rise[uart_regmap_pkg::STB_WR])
        begin
            case (wr_sel)
                uart_regmap_pkg::SEL_TX_HOLD:
                begin
                    d.tx_we   = 1'b1;
                    d.tx_data = bus_i.wdata;
                end
                uart_regmap_pkg::SEL_DIV_LOW:
                    d.cfg.divisor_low = bus_i.wdata;
                uart_regmap_pkg::SEL_DIV_HIGH:
                    d.cfg.divisor_high = bus_i.wdata;
                uart_regmap_pkg::SEL_INT_EN:
                    d.cfg.interrupt_enable = guarded(q.cfg.interrupt_enable, bus_i.wdata,
                        uart_regmap_pkg::INTEN_ENH_MASK, enh_en);
                uart_regmap_pkg::SEL_FIFO_CTRL:
                begin
                    d.cfg.fifo_control = guarded(q.cfg.fifo_control, bus_i.wdata,
                        uart_regmap_pkg::FIFO_ENH_MASK, enh_en);
                    d.fifo_we = 1'b1;
                end
                uart_regmap_pkg::SEL_ENH_FEAT:
                    d.cfg.enhanced_feature = bus_i.wdata;
                uart_regmap_pkg::SEL_FLOW_THR:
                    d.cfg.flow_threshold = bus_i.wdata;
                uart_regmap_pkg::SEL_LINE_CTRL:
                    d.cfg.line_control = bus_i.wdata;
                uart_regmap_pkg::SEL_MODEM_CTRL:
                    d.cfg.modem_control = guarded(q.cfg.modem_control, bus_i.wdata,
                        uart_regmap_pkg::MODEM_ENH_MASK, enh_en);
                uart_regmap_pkg::SEL_SCRATCH:
                    d.cfg.scratch_pad = bus_i.wdata;
                uart_regmap_pkg::SEL_RESUME_1:
                    d.cfg.resume_char_1 = bus_i.wdata;
                uart_regmap_pkg::SEL_RESUME_2:
                    d.cfg.resume_char_2 = bus_i.wdata;
                uart_regmap_pkg::SEL_PAUSE_1:
                    d.cfg.pause_char_1 = bus_i.wdata;
                uart_regmap_pkg::SEL_PAUSE_2:
                    d.cfg.pause_char_2 = bus_i.wdata;
                uart_regmap_pkg::SEL_TRIG_LVL:
                    d.cfg.trigger_level = bus_i.wdata;
                default:
                    d.cfg = d.cfg;
            endcase
        end

        // Read path. The value is captured once, at the start of the strobe,
        // so a slow host never sees it change in the middle of a read.
        if (rise[uart_regmap_pkg::STB_RD])
        begin
            case (rd_sel)
                uart_regmap_pkg::SEL_RX_HOLD:
                begin
                    d.rdata = status_i.rx_holding;
                    d.rx_re = 1'b1;
                end
                uart_regmap_pkg::SEL_DIV_LOW:    d.rdata = q.cfg.divisor_low;
                uart_regmap_pkg::SEL_DIV_HIGH:   d.rdata = q.cfg.divisor_high;
                uart_regmap_pkg::SEL_INT_EN:     d.rdata = q.cfg.interrupt_enable;
                uart_regmap_pkg::SEL_INT_IDENT:  d.rdata = status_i.interrupt_ident;
                uart_regmap_pkg::SEL_ENH_FEAT:   d.rdata = q.cfg.enhanced_feature;
                uart_regmap_pkg::SEL_FLOW_THR:   d.rdata = q.cfg.flow_threshold;
                uart_regmap_pkg::SEL_LINE_CTRL:  d.rdata = q.cfg.line_control;
                uart_regmap_pkg::SEL_MODEM_CTRL: d.rdata = q.cfg.modem_control;
                uart_regmap_pkg::SEL_LINE_STAT:  d.rdata = status_i.line_status;
                uart_regmap_pkg::SEL_MODEM_STAT: d.rdata = status_i.modem_status;
                uart_regmap_pkg::SEL_SCRATCH:    d.rdata = q.cfg.scratch_pad;
                uart_regmap_pkg::SEL_RESUME_1:   d.rdata = q.cfg.resume_char_1;
                uart_regmap_pkg::SEL_RESUME_2:   d.rdata = q.cfg.resume_char_2;
                uart_regmap_pkg::SEL_PAUSE_1:    d.rdata = q.cfg.pause_char_1;
                uart_regmap_pkg::SEL_PAUSE_2:    d.rdata = q.cfg.pause_char_2;
                uart_regmap_pkg::SEL_TRIG_LVL:   d.rdata = q.cfg.trigger_level;
                uart_regmap_pkg::SEL_FIFO_RDY:   d.rdata = frdy;
                default:                         d.rdata = uart_regmap_pkg::REG_RESET;
            endcase
        end
    end

    // State register; every field has a constant reset value.
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            q           <= '0;
            q.data_oe_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs come straight from the state register.
    assign rdata_o              = q.rdata;
    assign data_oe_n_o          = q.data_oe_n;
    assign tx_write_o           = q.tx_we;
    assign tx_data_o            = q.tx_data;
    assign rx_read_o            = q.rx_re;
    assign fifo_control_write_o = q.fifo_we;
    assign config_o             = q.cfg;

endmodule : uart_register_map_decode
`default_nettype wire

/* File: test/uart_regmap_properties.sv */
// Purpose: Concurrent checks on the channel register map decode ports.
// Assumes: Single clock domain; strobes and selects are active low.
// Notes:   Decode is judged against the register values seen at the take edge.
`timescale 1ns/1ps
`default_nettype none
module uart_regmap_properties (
    input  wire logic                       sys_clk_i,
    input  wire logic                       nrst_i,
    input  wire uart_regmap_pkg::host_bus_s bus_i,
    input  wire uart_regmap_pkg::status_s   status_i,
    input  wire logic [7:0]                 rdata_o,
    input  wire logic                       data_oe_n_o,
    input  wire logic                       tx_write_o,
    input  wire logic [7:0]                 tx_data_o,
    input  wire logic                       rx_read_o,
    input  wire logic                       fifo_control_write_o,
    input  wire uart_regmap_pkg::cfg_s      config_o
);
    logic wr_lvl, rd_lvl, wr_take, rd_take, keyed, lvl_on, enh;
    logic wr_prev_q, rd_prev_q;

    // An access is taken only on the first edge of a held strobe.
    assign wr_lvl  = !bus_i.wr_n && !bus_i.channel_a_select_n;
    assign rd_lvl  = !bus_i.rd_n && !bus_i.channel_a_select_n;
    assign wr_take = wr_lvl && !wr_prev_q;
    assign rd_take = rd_lvl && !rd_prev_q;
    assign keyed   = config_o.line_control == 8'hbf;
    assign enh     = config_o.enhanced_feature[4];
    assign lvl_on  = enh && config_o.modem_control[6];

    // Previous strobe levels, cleared in reset so no access is invented.
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wr_prev_q <= 1'b0;
            rd_prev_q <= 1'b0;
        end
        else
        begin
            wr_prev_q <= wr_lvl;
            rd_prev_q <= rd_lvl;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    // Each check but chk_idle_release ties an output to the access that caused it; that one ties the bus enable to an idle read strobe.
    chk_div_low_write: assert property (wr_take && bus_i.addr == 3'h0 && config_o.line_control[7]
        |=> config_o.divisor_low == $past(bus_i.wdata)) else $error("divisor low not written");
    chk_tx_hold_pulse: assert property (wr_take && bus_i.addr == 3'h0 && !config_o.line_control[7]
        |=> tx_write_o && tx_data_o == $past(bus_i.wdata) ##1 !tx_write_o)
        else $error("transmit write pulse wrong");
    chk_rx_read_pulse: assert property (rd_take && bus_i.addr == 3'h0 && !config_o.line_control[7]
        |=> rx_read_o ##1 !rx_read_o) else $error("receive read pulse wrong");
    chk_key_feature: assert property (wr_take && bus_i.addr == 3'h2 && keyed
        |=> config_o.enhanced_feature == $past(bus_i.wdata)) else $error("feature write lost");
    chk_flow_lvl_write: assert property (wr_take && bus_i.addr == 3'h2 && !keyed && lvl_on
        |=> config_o.flow_threshold == $past(bus_i.wdata) && !fifo_control_write_o)
        else $error("flow threshold write wrong");
    chk_fifo_ctrl_pulse: assert property (wr_take && bus_i.addr == 3'h2 && !keyed && !lvl_on
        |=> fifo_control_write_o ##1 !fifo_control_write_o) else $error("fifo control pulse wrong");
    chk_fifo_rdy_read: assert property (rd_take && bus_i.addr == 3'h7 && !keyed && !lvl_on
        && !bus_i.channel_b_select_n && config_o.modem_control[2] && !config_o.modem_control[4]
        |=> rdata_o == {2'h0, $past(status_i.rx_fifo_b), $past(status_i.rx_fifo_a), 2'h0,
            $past(status_i.tx_fifo_b), $past(status_i.tx_fifo_a)}) else $error("ready summary wrong");
    chk_prescale_lock: assert property (wr_take && bus_i.addr == 3'h4 && !keyed && !enh
        |=> $stable(config_o.modem_control[7:5])) else $error("locked modem bits changed");
    chk_ier_lock: assert property (wr_take && bus_i.addr == 3'h1 && !config_o.line_control[7] && !enh
        |=> config_o.interrupt_enable == {$past(config_o.interrupt_enable[7:4]),
            $past(bus_i.wdata[3:0])}) else $error("locked enable bits changed");
    chk_ro_write: assert property (wr_take && bus_i.addr == 3'h5 && !keyed
        |=> $stable(config_o)) else $error("read-only write changed state");
    chk_read_enable: assert property (rd_take |=> !data_oe_n_o) else $error("data not driven");
    chk_idle_release: assert property ($past(bus_i.rd_n) |-> data_oe_n_o) else $error("bus driven idle");
endmodule : uart_regmap_properties

bind uart_register_map_decode uart_regmap_properties chk_i (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .bus_i(bus_i), .status_i(status_i),
    .rdata_o(rdata_o), .data_oe_n_o(data_oe_n_o), .tx_write_o(tx_write_o),
    .tx_data_o(tx_data_o), .rx_read_o(rx_read_o),
    .fifo_control_write_o(fifo_control_write_o), .config_o(config_o)
);
`default_nettype wire

/* File: test/uart_host_model.sv */
// Purpose: Host processor model that drives the parallel register bus.
// Assumes: Signals change at the falling clock edge; strobes last two cycles.
// Notes:   Released address and data show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module uart_host_model (
    input  wire logic                      sys_clk_i,
    input  wire logic [7:0]                rdata_i,
    output var  uart_regmap_pkg::host_bus_s bus_o
);
    // Idle bus from time zero, both selects released.
    initial bus_o = '{3'h0, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1};

    // One access: address plus strobe pick the register, then an idle cycle follows.
    task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                          input logic both, output logic [7:0] q);
        @(negedge sys_clk_i);
        bus_o = '{a, d, wr, !wr, 1'b0, !both};
        @(negedge sys_clk_i);
        q = rdata_i;
        @(negedge sys_clk_i);
        bus_o = '{~a, ~d, 1'b1, 1'b1, 1'b1, 1'b1};
        @(negedge sys_clk_i);
    endtask : access
endmodule : uart_host_model
`default_nettype wire

/* File: test/uart_register_map_decode_tb_top.sv */
// Purpose: Self-checking bench for the channel register map decode.
// Assumes: Host model drives the bus; status inputs are held by the bench.
// Notes:   Expected values follow the decode and locking rules, not the outputs.
`timescale 1ns/1ps
`default_nettype none
module uart_register_map_decode_tb_top;
    logic                       sys_clk_i, nrst_i;
    uart_regmap_pkg::host_bus_s bus;
    uart_regmap_pkg::status_s   status;
    uart_regmap_pkg::cfg_s      cfg, saved;
    logic [7:0]                 rdata, tx_data;
    logic                       oe_n, tx_wr, rx_rd, fifo_wr;
    int                         failures, check_count, tx_count, rx_count;

    uart_register_map_decode dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .bus_i(bus),
        .status_i(status), .rdata_o(rdata), .data_oe_n_o(oe_n), .tx_write_o(tx_wr),
        .tx_data_o(tx_data), .rx_read_o(rx_rd), .fifo_control_write_o(fifo_wr), .config_o(cfg));
    uart_host_model host (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .bus_o(bus));

    // Free-running 25 MHz clock.
    initial
    begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    // Pulse counters, so one-cycle strobes are never missed between checks.
    always @(posedge sys_clk_i)
    begin
        if (tx_wr === 1'b1) tx_count++;
        if (rx_rd === 1'b1) rx_count++;
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin failures++; $display("mismatch at %0t: got %h expected %h", $time, got, exp); end
    endtask : cmp

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.access(1'b1, a, d, 1'b0, q);
    endtask : wr

    task automatic rd_chk(input logic [2:0] a, input logic both, input logic [7:0] exp);
        logic [7:0] q;
        host.access(1'b0, a, 8'h00, both, q);
        cmp(q, exp);
    endtask : rd_chk

    task automatic print_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic s_divisor();
        int n;
        wr(3'h3, 8'h80);
        wr(3'h0, 8'h12);
        wr(3'h1, 8'h34);
        rd_chk(3'h0, 1'b0, 8'h12);
        rd_chk(3'h1, 1'b0, 8'h34);
        n = tx_count;
        wr(3'h3, 8'h03);
        wr(3'h0, 8'h55);
        cmp(tx_data, 8'h55);
        cmp(8'(tx_count - n), 8'h01);
        cmp(cfg.divisor_low, 8'h12);
        rd_chk(3'h0, 1'b0, 8'h6b);
        cmp(8'(rx_count), 8'h01);
    endtask : s_divisor

    task automatic s_key();
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h10);
        for (int i = 4; i < 8; i++) wr(3'(i), 8'(8'ha0 + i));
        cmp(cfg.enhanced_feature, 8'h10);
        cmp(cfg.resume_char_1, 8'ha4);
        cmp(cfg.resume_char_2, 8'ha5);
        cmp(cfg.pause_char_2, 8'ha7);
        rd_chk(3'h6, 1'b0, 8'ha6);
        wr(3'h3, 8'h03);
        cmp(cfg.modem_control, 8'h00);
        rd_chk(3'h2, 1'b0, 8'hc1);
    endtask : s_key

    task automatic s_threshold();
        wr(3'h4, 8'h40);
        wr(3'h2, 8'h9a);
        wr(3'h7, 8'h3c);
        cmp(cfg.flow_threshold, 8'h9a);
        cmp(cfg.fifo_control, 8'h00);
        cmp(cfg.trigger_level, 8'h3c);
        cmp(cfg.scratch_pad, 8'h00);
    endtask : s_threshold

    task automatic s_fifo_ready();
        wr(3'h4, 8'h04);
        wr(3'h7, 8'h5e);
        rd_chk(3'h7, 1'b1, 8'h21);
        rd_chk(3'h7, 1'b0, 8'h5e);
        wr(3'h4, 8'h14);
        rd_chk(3'h7, 1'b1, 8'h5e);
    endtask : s_fifo_ready

    task automatic s_locked();
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h00);
        wr(3'h3, 8'h03);
        wr(3'h4, 8'hff);
        wr(3'h1, 8'hff);
        wr(3'h2, 8'hff);
        cmp(cfg.modem_control, 8'h1f);
        cmp(cfg.interrupt_enable, 8'h0f);
        cmp(cfg.fifo_control, 8'hc9);
        saved = cfg;
        wr(3'h5, 8'haa);
        cmp({7'h00, cfg === saved}, 8'h01);
        rd_chk(3'h5, 1'b0, 8'h60);
        rd_chk(3'h2, 1'b0, 8'hc1);
        rd_chk(3'h6, 1'b0, 8'h3d);
    endtask : s_locked

    // Watchdog: the whole sequence needs about 150 cycles, well under the 3000-cycle limit.
    initial
    begin
        #(40 * 3000);
        failures++;
        print_verdict();
    end

    // Main sequence: reset for six cycles, then each scenario in turn.
    initial
    begin
        nrst_i = 1'b0;
        status = '{8'h6b, 8'hc1, 8'h60, 8'h3d, 1'b1, 1'b0, 1'b0, 1'b1};
        repeat (6) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        cmp(cfg.line_control, 8'h00);
        cmp({7'h00, oe_n}, 8'h01);
        s_divisor();
        s_key();
        s_threshold();
        s_fifo_ready();
        s_locked();
        print_verdict();
    end
endmodule : uart_register_map_decode_tb_top
`default_nettype wire
